// file: src/ppa_top.sv
// Dual 8-bit parallel peripheral adapter with strobe-timed processor bus
// Functional notes
// - selected when both positive selects high, negative low
// - any inactive select deselects the device
// - data drivers off except selected reads
// - low read/write writes addressed location during strobe
// - read drivers on only with select and strobe
// - enable strobe fall times writes and clears; drivers follow its level
// - reset clears every register bit
// - interrupt requests are open drain, pull low only
// - two masked flags drive each request
// - data register read clears section flags
// - cleared flag rearmed only by deselected strobe
// - strobe between edges arms edge detector
// - armed enabled flag sets on active edge
// - direction bit one output, zero input
// - input lines read live pin levels
// - output lines drive stored register bits
// - port A output bits read pin level
// - port B output bits read stored value
// - port B input lines are high impedance
// - dedicated inputs set flags, polarity programmable
// - control line selectable input or output
// - register selects plus bit 2 choose location
// - flag bits read-only, set by lines
// - bit 0 enables request, bit 1 polarity
// - bit 5 picks control line direction
`timescale 1ns/100ps
`include "ppa_defs.svh"
module ppa_top
  import ppa_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Processor data bus
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataEnN,
  // Processor selects and strobe
  input wire logic selectPosFirst,
  input wire logic selectPosSecond,
  input wire logic selectNegN,
  input wire logic regSelLow,
  input wire logic regSelHigh,
  input wire logic readNotWrite,
  input wire logic enableStrobe,
  // Interrupt requests, open drain
  output logic intReqANOut,
  output logic intReqANEnN,
  output logic intReqBNOut,
  output logic intReqBNEnN,
  // Peripheral port A
  input wire logic [7:0] portALinesIn,
  output logic [7:0] portALinesOut,
  output logic [7:0] portALinesEnN,
  // Peripheral port B
  input wire logic [7:0] portBLinesIn,
  output logic [7:0] portBLinesOut,
  output logic [7:0] portBLinesEnN,
  // Dedicated interrupt inputs
  input wire logic irqInA,
  input wire logic irqInB,
  // Programmable control lines
  input wire logic ctlLineAIn,
  output logic ctlLineAOut,
  output logic ctlLineAEnN,
  input wire logic ctlLineBIn,
  output logic ctlLineBOut,
  output logic ctlLineBEnN
);
  // Synchronised pin levels
  logic [`PPA_SYNC_W-1:0] pinsRaw;
  logic [`PPA_SYNC_W-1:0] pinsSync;
  ppa_byte_t dataS;
  ppa_byte_t portSync [0:1];
  logic [1:0] irqSync;
  logic [1:0] ctlSync;
  logic csFirstS, csSecondS, csNegS;
  logic rsHighS, rsLowS, rwS, strobeS;

  // Strobe timing
  logic strobePrev, next_strobePrev;
  logic strobeFall;
  logic deselFall;
  logic selected;
  logic driveNow;

  // Read path
  ppa_byte_t readData, next_readData;
  logic nextDataEnN, next_dataEnN;

  // Per-section results
  ppa_byte_t secRead [0:1];
  ppa_byte_t outRegW [0:1];
  ppa_byte_t dirRegW [0:1];
  logic [5:0] ctlRegW [0:1];
  logic [1:0] irqAct;

  // Every pin crosses two flops before any logic sees it
  // Costs two clocks of latency, but no pin can go metastable in logic
  assign pinsRaw = {dataIn, portALinesIn, portBLinesIn, irqInA, irqInB,
                    ctlLineAIn, ctlLineBIn, selectPosFirst, selectPosSecond,
                    selectNegN, regSelHigh, regSelLow, readNotWrite,
                    enableStrobe};

  ppa_sync #(
    .WIDTH(`PPA_SYNC_W)
  ) uSync (
    .clock(clock),
    .rstn(rstn),
    .async(pinsRaw),
    .sync(pinsSync)
  );

  // Unpack the synchronised bundle
  assign dataS = pinsSync[34:27];
  assign portSync[0] = pinsSync[26:19];
  assign portSync[1] = pinsSync[18:11];
  assign irqSync = {pinsSync[9], pinsSync[10]};
  assign ctlSync = {pinsSync[7], pinsSync[8]};
  assign csFirstS = pinsSync[6];
  assign csSecondS = pinsSync[5];
  assign csNegS = pinsSync[4];
  assign rsHighS = pinsSync[3];
  assign rsLowS = pinsSync[2];
  assign rwS = pinsSync[1];
  assign strobeS = pinsSync[0];

  // Select decode; selects are taken as stable across the strobe
  assign selected = csFirstS & csSecondS & ~csNegS;

  // Strobe fall detection times writes, clears and arming; the drivers follow the strobe level
  assign next_strobePrev = strobeS;
  assign strobeFall = strobePrev & ~strobeS;
  assign deselFall = strobeFall & ~selected;

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      strobePrev <= 1'b0;
    else
      strobePrev <= next_strobePrev;

  // One block per section: registers, decode and two edge lines
  for (genvar s = 0; s < 2; s++)
  begin : gSec
    localparam logic SEC = 1'(s);
    ppa_byte_t outReg, next_outReg;
    ppa_byte_t dirReg, next_dirReg;
    logic [5:0] ctlReg, next_ctlReg;
    ppa_loc_e loc;
    logic hit;
    logic wrEv;
    logic dataRdEv;
    ppa_byte_t pinRead;
    ppa_line_if line1 ();
    ppa_line_if line2 ();

    // Register selects with bit 2 pick the location
    assign hit = selected & (rsHighS == SEC);
    always_comb
    begin
      if (rsLowS)
        loc = LOC_CTL;
      else if (ctlReg[`PPA_CTL_DIR_ACC])
        loc = LOC_DATA;
      else
        loc = LOC_DIR;
    end

    // Bus events land on the strobe's falling edge
    assign wrEv = strobeFall & hit & ~rwS;
    assign dataRdEv = strobeFall & hit & rwS & (loc == LOC_DATA);

    // Writes; flag bits have no write path
    always_comb
    begin
      next_outReg = outReg;
      next_dirReg = dirReg;
      next_ctlReg = ctlReg;
      if (wrEv)
      begin
        case (loc)
          LOC_DATA: next_outReg = dataS;
          LOC_DIR: next_dirReg = dataS;
          LOC_CTL: next_ctlReg = dataS[5:0];
          default: next_ctlReg = ctlReg;
        endcase
      end
    end

    always_ff @(posedge clock or negedge rstn)
      if (!rstn)
      begin
        outReg <= `PPA_BYTE_RESET;
        dirReg <= `PPA_BYTE_RESET;
        ctlReg <= `PPA_CTL_RESET;
      end
      else
      begin
        outReg <= next_outReg;
        dirReg <= next_dirReg;
        ctlReg <= next_ctlReg;
      end

    // Port A reads the pin even on outputs, so loading shows through
    assign pinRead = (s == `PPA_SEC_A) ? portSync[s]
                   : ((dirReg & outReg) | (~dirReg & portSync[s]));

    // Readback of the addressed location
    always_comb
    begin
      case (loc)
        LOC_DATA: secRead[s] = pinRead;
        LOC_DIR: secRead[s] = dirReg;
        LOC_CTL: secRead[s] = {line1.flag, line2.flag, ctlReg};
        default: secRead[s] = `PPA_BYTE_RESET;
      endcase
    end

    // Dedicated input: always an input, polarity from bit 1
    assign line1.pin = irqSync[s];
    assign line1.activeHigh = ctlReg[`PPA_CTL_EDGE1_POS];
    assign line1.lineEn = 1'b1;
    assign line1.strobe = strobeFall;
    assign line1.deselStrobe = deselFall;
    assign line1.clear = dataRdEv;

    // Programmable line senses edges only while bit 5 is low
    assign line2.pin = ctlSync[s];
    assign line2.activeHigh = ctlReg[`PPA_CTL_EDGE2_POS];
    assign line2.lineEn = ~ctlReg[`PPA_CTL_LINE2_OUT];
    assign line2.strobe = strobeFall;
    assign line2.deselStrobe = deselFall;
    assign line2.clear = dataRdEv;

    ppa_edge uEdge1 (
      .clock(clock),
      .rstn(rstn),
      .line(line1)
    );

    ppa_edge uEdge2 (
      .clock(clock),
      .rstn(rstn),
      .line(line2)
    );

    // Each flag has its own enable bit
    assign irqAct[s] = (line1.flag & ctlReg[`PPA_CTL_IRQ1_EN])
                     | (line2.flag & ctlReg[`PPA_CTL_IRQ2_EN]);

    assign outRegW[s] = outReg;
    assign dirRegW[s] = dirReg;
    assign ctlRegW[s] = ctlReg;
  end

  // Drivers follow the strobe while a selected read is present
  // Sync latency keeps drivers on three clocks past the strobe fall
  assign driveNow = strobeS & selected & rwS;

  // Read data tracks the live source while the drivers are on
  always_comb
  begin
    next_readData = readData;
    next_dataEnN = ~driveNow;
    if (driveNow)
      next_readData = secRead[rsHighS];
  end

  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      readData <= `PPA_BYTE_RESET;
      nextDataEnN <= 1'b1;
    end
    else
    begin
      readData <= next_readData;
      nextDataEnN <= next_dataEnN;
    end

  assign dataOut = readData;
  assign dataEnN = nextDataEnN;

  // Open drain: the level is always low, only the enable moves
  assign intReqANOut = 1'b0;
  assign intReqANEnN = ~irqAct[0];
  assign intReqBNOut = 1'b0;
  assign intReqBNEnN = ~irqAct[1];

  // Port lines drive stored bits where the direction bit is one
  assign portALinesOut = outRegW[0];
  assign portALinesEnN = ~dirRegW[0];
  assign portBLinesOut = outRegW[1];
  assign portBLinesEnN = ~dirRegW[1];

  // Output mode of the control lines: plain level from bit 3 only
  // Handshake output modes are not built; bit 3 is a static level
  assign ctlLineAOut = ctlRegW[0][`PPA_CTL_IRQ2_EN];
  assign ctlLineAEnN = ~ctlRegW[0][`PPA_CTL_LINE2_OUT];
  assign ctlLineBOut = ctlRegW[1][`PPA_CTL_IRQ2_EN];
  assign ctlLineBEnN = ~ctlRegW[1][`PPA_CTL_LINE2_OUT];
endmodule : ppa_top

// file: common/ppa_defs.svh
// Constants of the parallel peripheral adapter: field positions and reset values
`ifndef PPA_DEFS_SVH
`define PPA_DEFS_SVH
`define PPA_BYTE_RESET 8'h00
`define PPA_CTL_RESET 6'h00
`define PPA_CTL_IRQ1_EN 0
`define PPA_CTL_EDGE1_POS 1
`define PPA_CTL_DIR_ACC 2
`define PPA_CTL_IRQ2_EN 3
`define PPA_CTL_EDGE2_POS 4
`define PPA_CTL_LINE2_OUT 5
`define PPA_SEC_A 0
`define PPA_SYNC_W 35
`endif

// file: common/ppa_pkg.sv
// Types shared by the parallel peripheral adapter modules
package ppa_pkg;
  // Location addressed inside one section
  typedef enum logic [1:0] {LOC_DATA, LOC_DIR, LOC_CTL} ppa_loc_e;
  typedef logic [7:0] ppa_byte_t;
endpackage : ppa_pkg

// file: common/ppa_line_if.sv
// Signals between a section and one edge-sensing control line
`timescale 1ns/100ps
interface ppa_line_if;
  logic pin;
  logic activeHigh;
  logic lineEn;
  logic strobe;
  logic deselStrobe;
  logic clear;
  logic flag;
  modport det (
    input pin, activeHigh, lineEn, strobe, deselStrobe, clear,
    output flag
  );
  modport ctrl (
    output pin, activeHigh, lineEn, strobe, deselStrobe, clear,
    input flag
  );
endinterface : ppa_line_if

// file: src/ppa_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module ppa_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Levels
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      stage1 <= '0;
      sync <= '0;
    end
    else
    begin
      stage1 <= async;
      sync <= stage1;
    end
endmodule : ppa_sync

// file: src/ppa_edge.sv
// Edge-sensing interrupt flag of one control line
`timescale 1ns/100ps
module ppa_edge (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Line towards the section
  ppa_line_if.det line
);
  logic prevPin, next_prevPin;
  logic armed, next_armed;
  logic reEn, next_reEn;
  logic flag, next_flag;
  logic atInactive;
  logic activeEdge;

  // A polarity change alone is no edge: only pin changes count
  assign atInactive = line.pin != line.activeHigh;
  assign activeEdge = (line.pin != prevPin) & ~atInactive;

  // Arming, re-enable and flag next values
  always_comb
  begin
    next_prevPin = line.pin;
    next_armed = armed;
    next_reEn = reEn;
    next_flag = flag;
    if (line.strobe && atInactive)
      next_armed = 1'b1;
    else if (activeEdge)
      next_armed = 1'b0;
    if (line.deselStrobe)
      next_reEn = 1'b1;
    if (line.clear)
    begin
      next_reEn = 1'b0;
      next_flag = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (activeEdge && armed && reEn && line.lineEn)
      next_flag = 1'b1;
  end

  // State registers, all zero under reset
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      prevPin <= 1'b0;
      armed <= 1'b0;
      reEn <= 1'b0;
      flag <= 1'b0;
    end
    else
    begin
      prevPin <= next_prevPin;
      armed <= next_armed;
      reEn <= next_reEn;
      flag <= next_flag;
    end

  assign line.flag = flag;
endmodule : ppa_edge

// file: verif/ppa_top_checker.sv
// Concurrent checks on the adapter's pins
`timescale 1ns/100ps
module ppa_top_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Bus side
  input wire logic dataEnN,
  input wire logic selectPosFirst,
  input wire logic selectPosSecond,
  input wire logic selectNegN,
  input wire logic readNotWrite,
  input wire logic enableStrobe,
  // Peripheral side
  input wire logic intReqANOut,
  input wire logic intReqBNOut,
  input wire logic intReqANEnN,
  input wire logic [7:0] portALinesEnN,
  input wire logic [7:0] portBLinesEnN,
  input wire logic [7:0] portALinesOut,
  input wire logic ctlLineAEnN,
  input wire logic ctlLineBEnN
);
  // Pins pass two sync flops and one register, hence the depth of three
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  AST_OPEN_DRAIN: assert property (intReqANOut == 1'h0 && intReqBNOut == 1'h0)
    else $error("request pin level not low");
  AST_READ_RW: assert property (!dataEnN |-> $past(readNotWrite, 3))
    else $error("bus driven outside a read");
  AST_READ_SELECT: assert property (!dataEnN |->
    $past(selectPosFirst, 3) && $past(selectPosSecond, 3) && !$past(selectNegN, 3))
    else $error("bus driven while deselected");
  AST_READ_STROBE: assert property (!dataEnN |-> $past(enableStrobe, 3))
    else $error("bus driven without strobe");
  AST_PORT_WRITE: assert property ($changed(portALinesEnN) || $changed(portBLinesEnN)
    |-> !$past(readNotWrite, 4))
    else $error("direction changed without a write");
  // A write taken on the rising strobe edge would show strobe still high here
  AST_PORT_FALL: assert property ($changed(portALinesOut) |-> !$past(enableStrobe, 3))
    else $error("port output changed before strobe fall");
  AST_CTL_WRITE: assert property ($changed(ctlLineAEnN) || $changed(ctlLineBEnN)
    |-> !$past(readNotWrite, 4))
    else $error("control line mode changed without a write");
  AST_RESET: assert property ($rose(rstn) |-> dataEnN && intReqANEnN && ctlLineAEnN
    && ctlLineBEnN && portALinesEnN == 8'hff && portBLinesEnN == 8'hff)
    else $error("outputs not at reset state");
  // Main scenarios
  cover property (!dataEnN);
  cover property ($fell(intReqANEnN));
  cover property ($changed(portBLinesEnN));
endmodule : ppa_top_checker

bind ppa_top ppa_top_checker u_chk (
  .clock(clock), .rstn(rstn), .dataEnN(dataEnN), .selectPosFirst(selectPosFirst),
  .selectPosSecond(selectPosSecond), .selectNegN(selectNegN), .readNotWrite(readNotWrite),
  .enableStrobe(enableStrobe), .intReqANOut(intReqANOut), .intReqBNOut(intReqBNOut),
  .intReqANEnN(intReqANEnN), .portALinesEnN(portALinesEnN), .portBLinesEnN(portBLinesEnN),
  .portALinesOut(portALinesOut), .ctlLineAEnN(ctlLineAEnN), .ctlLineBEnN(ctlLineBEnN)
);

// file: verif/ppa_periph_model.sv
// Peripheral devices and pin levels facing the two ports
`timescale 1ns/100ps
module ppa_periph_model (
  // Adapter drive
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portAEnN,
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portBEnN,
  input wire logic ctlBOut,
  input wire logic ctlBEnN,
  // Peripheral drive and loading
  input wire logic [7:0] periA,
  input wire logic [7:0] periB,
  input wire logic [7:0] loadA,
  input wire logic [7:0] loadB,
  input wire logic ctlBPeri,
  // Resolved levels
  output logic [7:0] pinA,
  output logic [7:0] pinB,
  output logic ctlBPin
);
  // A heavy load keeps driven port A bits from reaching a high level
  assign pinA = (~portAEnN & portAOut & ~loadA) | (portAEnN & periA);
  // Port B readback must ignore this load on driven bits
  assign pinB = (~portBEnN & portBOut & ~loadB) | (portBEnN & periB);
  assign ctlBPin = ctlBEnN ? ctlBPeri : ctlBOut;
endmodule : ppa_periph_model

// file: verif/tb_ppa_top.sv
// Self-checking bench of the parallel peripheral adapter
`timescale 1ns/100ps
module tb_ppa_top;
  import ppa_pkg::*;
  localparam logic [2:0] SEL = 3'h6;
  logic clock = 1'h0, rstn = 1'h0, rw = 1'h1, strobe = 1'h0, int_req_a_n = 1'h0, int_req_b_n = 1'h1;
  logic periCtlB = 1'h1, dataEnN, reqAOut, reqAEnN, reqBOut, reqBEnN;
  logic ctlAOut, ctlAEnN, ctlBOut, ctlBEnN, ctlBPin;
  logic [2:0] sel = 3'h0;
  logic [1:0] rs = 2'h0;
  logic [7:0] dataIn = 8'h00, periA = 8'h00, periB = 8'h00, loadA = 8'h00;
  logic [7:0] dataOut, pinA, pinB, portAOut, portAEnN, portBOut, portBEnN;
  logic [7:0] rd, dirA, outA, dirB, outB;
  int fails = 0, comparisons = 0;
  always #4 clock = ~clock;
  ppa_top DUT (
    .clock(clock), .rstn(rstn), .dataIn(dataIn), .dataOut(dataOut), .dataEnN(dataEnN),
    .selectPosFirst(sel[2]), .selectPosSecond(sel[1]), .selectNegN(sel[0]),
    .regSelLow(rs[0]), .regSelHigh(rs[1]), .readNotWrite(rw), .enableStrobe(strobe),
    .intReqANOut(reqAOut), .intReqANEnN(reqAEnN), .intReqBNOut(reqBOut), .intReqBNEnN(reqBEnN),
    .portALinesIn(pinA), .portALinesOut(portAOut), .portALinesEnN(portAEnN),
    .portBLinesIn(pinB), .portBLinesOut(portBOut), .portBLinesEnN(portBEnN),
    .irqInA(int_req_a_n), .irqInB(int_req_b_n), .ctlLineAIn(ctlAEnN ? 1'h1 : ctlAOut),
    .ctlLineAOut(ctlAOut), .ctlLineAEnN(ctlAEnN), .ctlLineBIn(ctlBPin),
    .ctlLineBOut(ctlBOut), .ctlLineBEnN(ctlBEnN)
  );
  ppa_periph_model u_peri (
    .portAOut(portAOut), .portAEnN(portAEnN), .portBOut(portBOut), .portBEnN(portBEnN),
    .ctlBOut(ctlBOut), .ctlBEnN(ctlBEnN), .periA(periA), .periB(periB), .loadA(loadA),
    .loadB(loadA), .ctlBPeri(periCtlB), .pinA(pinA), .pinB(pinB), .ctlBPin(ctlBPin)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] level(input logic [7:0] dir, val, per, load);
    return (dir & val & ~load) | (~dir & per);
  endfunction : level
  // One strobe cycle; selects stay put well past both strobe edges
  task automatic cyc(input logic [2:0] s, input logic [1:0] r, input logic w,
    input logic [7:0] d);
    sel <= s;
    rs <= r;
    rw <= w;
    dataIn <= d;
    repeat (3) @(posedge clock);
    strobe <= 1'h1;
    repeat (6) @(posedge clock);
    rd = dataOut;
    check({7'h0, dataEnN}, {7'h0, !(w && s == SEL)});
    strobe <= 1'h0;
    repeat (8) @(posedge clock); // Selects held well past the fall
    sel <= 3'h0;
    rw <= 1'h1;
    @(posedge clock);
  endtask : cyc
  task automatic setPort(input logic sec, input logic [7:0] dir, input logic [7:0] val);
    cyc(SEL, {sec, 1'h1}, 1'h0, 8'h00);
    cyc(SEL, {sec, 1'h0}, 1'h0, dir);
    cyc(SEL, {sec, 1'h1}, 1'h0, 8'h04);
    cyc(SEL, {sec, 1'h0}, 1'h0, val);
  endtask : setPort
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // Watchdog well beyond the roughly 1,550 cycles the tests need
  initial
  begin
    #(8 * 20000);
    fails++;
    summarize();
  end
  initial
  begin
    void'($urandom(80304));
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    repeat (4) @(posedge clock);
    check(portAEnN & portBEnN, 8'hff);
    check({dataEnN, reqAEnN, reqBEnN, ctlAEnN, ctlBEnN, 3'h0}, 8'hf8);
    check({5'h0, ctlAOut, ctlBOut, reqAOut | reqBOut}, 8'h00);
    cyc(SEL, 2'h3, 1'h1, 8'h00);
    check(rd, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      dirA = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      dirB = ~dirA;
      outA = 8'($urandom);
      outB = 8'($urandom);
      periA <= 8'($urandom);
      periB <= 8'($urandom);
      loadA <= 8'($urandom);
      setPort(1'h0, dirA, outA);
      setPort(1'h1, dirB, outB);
      check(portAEnN, ~dirA);
      check(portAOut, outA);
      check(portBEnN, ~dirB);
      check(portBOut, outB);
      cyc(SEL, 2'h0, 1'h1, 8'h00);
      check(rd, level(dirA, outA, periA, loadA));
      cyc(SEL, 2'h2, 1'h1, 8'h00);
      check(rd, level(dirB, outB, periB, 8'h00));
    end
    for (int k = 0; k < 3; k++)
    begin
      cyc(SEL ^ (3'h1 << k), 2'h0, 1'h0, ~outA);
      check(portAOut, outA);
      cyc(SEL ^ (3'h1 << k), 2'h0, 1'h1, 8'h00);
    end
    cyc(SEL, 2'h1, 1'h0, 8'hff);
    cyc(SEL, 2'h1, 1'h1, 8'h00);
    check(rd, 8'h3f);
    check({6'h0, ctlAEnN, ctlAOut}, 8'h01);
    cyc(SEL, 2'h3, 1'h0, 8'h28);
    check({6'h0, ctlBEnN, ctlBOut}, 8'h01);
    $display("port test done");
    // Reset again in mid-run: every register must return to zero
    rstn <= 1'h0;
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    repeat (4) @(posedge clock);
    check(portAEnN & portBEnN, 8'hff);
    check({6'h0, ctlAEnN, ctlBEnN}, 8'h03);
    cyc(SEL, 2'h1, 1'h1, 8'h00);
    check(rd, 8'h00);
    $display("mid-run reset test done");
    cyc(SEL, 2'h1, 1'h0, 8'h07);
    cyc(3'h0, 2'h0, 1'h1, 8'h00);
    int_req_a_n <= 1'h1;
    repeat (6) @(posedge clock);
    check({7'h0, reqAEnN}, 8'h00);
    cyc(SEL, 2'h1, 1'h1, 8'h00);
    check(rd, 8'h87);
    cyc(SEL, 2'h0, 1'h1, 8'h00);
    check({7'h0, reqAEnN}, 8'h01);
    int_req_a_n <= 1'h0;
    cyc(SEL, 2'h1, 1'h1, 8'h00);
    int_req_a_n <= 1'h1;
    repeat (6) @(posedge clock);
    check({7'h0, reqAEnN}, 8'h01);
    int_req_a_n <= 1'h0;
    cyc(3'h0, 2'h0, 1'h1, 8'h00);
    int_req_a_n <= 1'h1;
    repeat (6) @(posedge clock);
    check({7'h0, reqAEnN}, 8'h00);
    cyc(SEL, 2'h3, 1'h0, 8'h0c);
    cyc(3'h0, 2'h0, 1'h1, 8'h00);
    int_req_b_n <= 1'h0;
    repeat (6) @(posedge clock);
    check({7'h0, reqBEnN}, 8'h01);
    periCtlB <= 1'h0;
    repeat (6) @(posedge clock);
    check({7'h0, reqBEnN}, 8'h00);
    cyc(SEL, 2'h3, 1'h1, 8'h00);
    check(rd, 8'hcc);
    cyc(SEL, 2'h2, 1'h1, 8'h00);
    check({7'h0, reqBEnN}, 8'h01);
    // Re-enabled but never armed: no strobe between inactive and active edge
    cyc(SEL, 2'h0, 1'h1, 8'h00);
    cyc(3'h0, 2'h0, 1'h1, 8'h00);
    int_req_a_n <= 1'h0;
    repeat (6) @(posedge clock);
    int_req_a_n <= 1'h1;
    repeat (6) @(posedge clock);
    check({7'h0, reqAEnN}, 8'h01);
    $display("interrupt test done");
    summarize();
  end
endmodule : tb_ppa_top
